// file: src/codec_mode_control_status.v
// Mode-control and status register bank of the compression coprocessor
//
// Notes on behaviour
// - Mode field sits in control bits 7:5 at offset 0x00 and steers processing.
// - Modes: 0 A-to-B, 1 B-to-A, 2 comp, 3 flush, 4 decomp, 5 quiet, 6 reserved, 7 reset.
// - Pass-through moves bytes A to B or B to A unaltered.
// - Compression takes A and emits B; decompression takes B and emits A.
// - Flush compresses held data, appends end codeword, drives out on B.
// - Quiet decompression consumes B and builds dictionary but sends nothing on A.
// - Reset code clears engines, ports, arbiter, dictionary and soft-resets registers.
// - Reset pin sets mode bits to ones and clears control bits 4:0.
// - Bit 4 enables the ratio optimizer and its threshold and period settings.
// - Bit 3 clears dictionary after each record end during compression.
// - Bit 2 clears dictionary after current byte, then self-clears.
// - Bit 1 halts ports and engine after each record end and sets halted.
// - Bit 0 halts ports and engine; writing zero resumes from either halt.
// - Halt bit honored in the same write that leaves reset mode.
// - Optimizer and dictionary clears only in compression modes; halt bit in all, halt at record end only in codec modes.
// - Status at 0x01: bit2 mark count, bit1 empty, bit0 halted, rest zero.
// - Mark count tracks engine marks; cleared by reset, pass codes or reset pin.
// - Empty sets when record end leaves engine, clears when next record enters.
// - Empty set by pass or reset codes and by the reset pin.
// - While halted counts stay stable; halted set by reset pin and reset code.
// - Soft reset forces mode ones, keeps bits 4:0; status reads 0x03.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "codec_mode_map.vh"
module codec_mode_control_status (
  input wire i_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // Engine event inputs
  input wire i_record_end_mark,
  input wire i_mark_leaves_engine,
  input wire i_record_byte_enters,
  input wire i_dict_clear_done,
  // Control outputs toward the engine and ports
  output reg [2:0] o_operation_select_field,
  output reg o_ratio_optimizer_on,
  output reg o_clear_dictionary_per_record,
  output reg o_clear_dictionary_now,
  output reg o_halt,
  output reg o_soft_reset,
  output reg o_port_a_in_en,
  output reg o_port_a_out_en,
  output reg o_port_b_in_en,
  output reg o_port_b_out_en,
  output reg o_compress_en,
  output reg o_decompress_en,
  output reg o_flush_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg [2:0] mode_r;
  reg [4:0] ctrl_r;
  reg mark_count_r;
  reg empty_r;
  reg halted_r;
  reg [2:0] mode_nxt;
  reg [4:0] ctrl_nxt;
  reg mark_count_nxt;
  reg empty_nxt;
  reg halted_nxt;

  // Access decode: write lands only in the access phase, strobe on byte 0
  wire access_w = i_psel & i_penable;
  wire hit_ctrl = (i_paddr == `OPERATION_CONTROL_ADDR);
  wire hit_stat = (i_paddr == `ENGINE_STATE_FLAGS_ADDR);
  wire ctrl_wr = access_w & i_pwrite & hit_ctrl & i_pstrb[0];
  wire [2:0] wr_mode = i_pwdata[`MODE_MSB:`MODE_LSB];
  wire [4:0] wr_ctrl = i_pwdata[4:0];
  wire comp_mode = (mode_r == `MODE_COMP) | (mode_r == `MODE_COMP_FLUSH);
  wire codec_mode = comp_mode | (mode_r == `MODE_DECOMP) | (mode_r == `MODE_DECOMP_QUIET);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state of control and status
  always @* begin
    mode_nxt = mode_r;
    ctrl_nxt = ctrl_r;
    mark_count_nxt = mark_count_r;
    empty_nxt = empty_r;
    halted_nxt = halted_r;
    // Engine-side status moves only while running and in a codec mode
    if (codec_mode && !halted_r) begin
      if (i_record_end_mark && !i_mark_leaves_engine)
        mark_count_nxt = 1'b1;
      else if (i_mark_leaves_engine && !i_record_end_mark)
        mark_count_nxt = 1'b0;
      if (i_mark_leaves_engine)
        empty_nxt = 1'b1;
      else if (i_record_byte_enters)
        empty_nxt = 1'b0;
      // Halt at record end once the mark has gone through
      if (ctrl_r[`BIT_HALT_AT_END] && i_mark_leaves_engine)
        halted_nxt = 1'b1;
    end
    // Self-clear of the one-shot dictionary clear
    if (comp_mode && i_dict_clear_done)
      ctrl_nxt[`BIT_CLR_NOW] = 1'b0;
    if (ctrl_wr) begin
      if (wr_mode == `MODE_RESET) begin
        // Soft reset keeps bits 4:0, status back to its reset pattern
        mode_nxt = `MODE_RESET;
        mark_count_nxt = 1'b0;
        empty_nxt = 1'b1;
        halted_nxt = 1'b1;
      end else begin
        mode_nxt = wr_mode;
        ctrl_nxt = wr_ctrl;
        // A write that leaves reset takes its halt bit as given
        halted_nxt = wr_ctrl[`BIT_HALT];
        // Dictionary clear still pending wins over a write of zero that keeps the same compression mode
        if (comp_mode && ctrl_r[`BIT_CLR_NOW] && !i_dict_clear_done && mode_r == wr_mode)
          ctrl_nxt[`BIT_CLR_NOW] = ctrl_r[`BIT_CLR_NOW] | wr_ctrl[`BIT_CLR_NOW];
        // Halt-at-end already reached stays until halt is written zero
        if (halted_r && !wr_ctrl[`BIT_HALT] && mode_r != `MODE_RESET)
          halted_nxt = 1'b0;
        if (wr_mode == `MODE_PASS_AB || wr_mode == `MODE_PASS_BA) begin
          mark_count_nxt = 1'b0;
          empty_nxt = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; pin reset gives mode ones, bits cleared, status 0x03
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= 3'h7;
      ctrl_r <= 5'h00;
      mark_count_r <= 1'b0;
      empty_r <= 1'b1;
      halted_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
      mark_count_r <= mark_count_nxt;
      empty_r <= empty_nxt;
      halted_r <= halted_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: zero wait states, unmapped address gives pslverr
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~(hit_ctrl | hit_stat);
      if (i_psel && !i_penable && !i_pwrite && hit_ctrl)
        o_prdata <= {24'h00_0000, mode_r, ctrl_r};
      else if (i_psel && !i_penable && !i_pwrite && hit_stat)
        o_prdata <= {29'h0000_0000, mark_count_r, empty_r, halted_r};
      else
        o_prdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-path steering, registered from next state so it tracks the mode
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_operation_select_field <= 3'h7;
      o_ratio_optimizer_on <= 1'b0;
      o_clear_dictionary_per_record <= 1'b0;
      o_clear_dictionary_now <= 1'b0;
      o_halt <= 1'b1;
      o_soft_reset <= 1'b1;
      o_port_a_in_en <= 1'b0;
      o_port_a_out_en <= 1'b0;
      o_port_b_in_en <= 1'b0;
      o_port_b_out_en <= 1'b0;
      o_compress_en <= 1'b0;
      o_decompress_en <= 1'b0;
      o_flush_en <= 1'b0;
    end else begin
      o_operation_select_field <= mode_nxt;
      // Dictionary and optimizer controls act only in compression modes
      o_ratio_optimizer_on <= ctrl_nxt[`BIT_RATIO_OPT] & (mode_nxt[2:1] == 2'b01);
      o_clear_dictionary_per_record <= ctrl_nxt[`BIT_CLR_PER_REC] & (mode_nxt[2:1] == 2'b01);
      o_clear_dictionary_now <= ctrl_nxt[`BIT_CLR_NOW] & (mode_nxt[2:1] == 2'b01);
      o_halt <= halted_nxt;
      o_soft_reset <= (mode_nxt == `MODE_RESET);
      o_compress_en <= 1'b0;
      o_decompress_en <= 1'b0;
      o_flush_en <= 1'b0;
      o_port_a_in_en <= 1'b0;
      o_port_a_out_en <= 1'b0;
      o_port_b_in_en <= 1'b0;
      o_port_b_out_en <= 1'b0;
      if (!halted_nxt) begin
        case (mode_nxt)
          `MODE_PASS_AB: begin
            o_port_a_in_en <= 1'b1;
            o_port_b_out_en <= 1'b1;
          end
          `MODE_PASS_BA: begin
            o_port_b_in_en <= 1'b1;
            o_port_a_out_en <= 1'b1;
          end
          `MODE_COMP: begin
            o_port_a_in_en <= 1'b1;
            o_port_b_out_en <= 1'b1;
            o_compress_en <= 1'b1;
          end
          `MODE_COMP_FLUSH: begin
            o_port_b_out_en <= 1'b1;
            o_compress_en <= 1'b1;
            o_flush_en <= 1'b1;
          end
          `MODE_DECOMP: begin
            o_port_b_in_en <= 1'b1;
            o_port_a_out_en <= 1'b1;
            o_decompress_en <= 1'b1;
          end
          `MODE_DECOMP_QUIET: begin
            o_port_b_in_en <= 1'b1;
            o_decompress_en <= 1'b1;
          end
          default: begin
            // Reserved and reset codes leave every port idle
            o_port_a_in_en <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // codec_mode_control_status

// file: src/codec_mode_map.vh
// Register map, field positions and reset values of the mode-control block
`ifndef CODEC_MODE_MAP_VH
`define CODEC_MODE_MAP_VH
`define OPERATION_CONTROL_OFS 8'h00
`define ENGINE_STATE_FLAGS_OFS 8'h01
`define OPERATION_CONTROL_ADDR 12'h000
`define ENGINE_STATE_FLAGS_ADDR 12'h004
`define MODE_MSB 7
`define MODE_LSB 5
`define BIT_RATIO_OPT 4
`define BIT_CLR_PER_REC 3
`define BIT_CLR_NOW 2
`define BIT_HALT_AT_END 1
`define BIT_HALT 0
`define ST_MARK_COUNT 2
`define ST_EMPTY 1
`define ST_HALTED 0
`define MODE_PASS_AB 3'h0
`define MODE_PASS_BA 3'h1
`define MODE_COMP 3'h2
`define MODE_COMP_FLUSH 3'h3
`define MODE_DECOMP 3'h4
`define MODE_DECOMP_QUIET 3'h5
`define MODE_RESERVED 3'h6
`define MODE_RESET 3'h7
`define CTRL_HARD_RESET 8'he0
`define STATUS_RESET 8'h03
`endif

// file: verification/codec_mode_chk.sv
// Assertion checker for the mode-control block ports
`timescale 1ns/1ps
module codec_mode_chk (
  input wire i_clk, input wire i_rst_n, input wire i_psel, input wire i_penable,
  input wire i_pwrite, input wire [11:0] i_paddr, input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb, input wire [31:0] o_prdata, input wire o_pready,
  input wire [2:0] o_operation_select_field, input wire o_ratio_optimizer_on,
  input wire o_clear_dictionary_per_record, input wire o_clear_dictionary_now,
  input wire o_halt, input wire o_soft_reset, input wire o_port_a_in_en,
  input wire o_port_a_out_en, input wire o_port_b_in_en, input wire o_port_b_out_en,
  input wire o_compress_en, input wire o_decompress_en, input wire o_flush_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Accepted control write, mode and steering shorthands
  wire wr_c = i_psel & i_penable & i_pwrite & o_pready & i_pstrb[0] & (i_paddr == 12'h000);
  wire [2:0] md = o_operation_select_field;
  wire any_en = |{o_port_a_in_en, o_port_a_out_en, o_port_b_in_en, o_port_b_out_en,
    o_compress_en, o_decompress_en, o_flush_en};
  wire cbits = o_ratio_optimizer_on | o_clear_dictionary_per_record | o_clear_dictionary_now;
  ////////////////////////////////////////////////////////////////////////////////
  a_mode_written: assert property (wr_c |=> md == $past(i_pwdata[7:5]))
    else $error("mode differs from written value");
  a_halt_written: assert property (wr_c && i_pwdata[7:5] != 3'h7 |=> o_halt == $past(i_pwdata[0]))
    else $error("halt differs from written bit");
  a_soft_reset_mode: assert property (wr_c && i_pwdata[7:5] == 3'h7 |=> o_halt && o_soft_reset)
    else $error("reset code did not halt");
  a_halt_idles: assert property (o_halt |-> !any_en)
    else $error("steering active while halted");
  a_reserved_idle: assert property (md == 3'h6 |-> !any_en)
    else $error("steering active in reserved mode");
  a_bits_gated: assert property (md[2:1] != 2'b01 |-> !cbits)
    else $error("compression controls outside compression");
  a_comp_steer: assert property (md == 3'h2 && !o_halt |-> o_compress_en && o_port_a_in_en
    && o_port_b_out_en && !o_decompress_en)
    else $error("compression steering wrong");
  a_pass_steer: assert property (md == 3'h0 && !o_halt |-> o_port_a_in_en && o_port_b_out_en
    && !o_compress_en)
    else $error("pass steering wrong");
  a_quiet_output: assert property (md == 3'h5 |-> !o_port_a_out_en)
    else $error("quiet mode drives port A");
  a_read_pulse: assert property (o_pready |-> o_prdata[31:8] == 24'h0 ##1 !o_pready)
    else $error("read data or ready wrong");
endmodule // codec_mode_chk
bind codec_mode_control_status codec_mode_chk i_chk (.*);

// file: verification/engine_event_model.sv
// Event source standing in for the compression engine
`timescale 1ns/1ps
module engine_event_model (
  input wire i_clk,
  output reg [3:0] o_ev
);
  initial o_ev = 4'h0;
  // One-cycle pulse: 0 mark in, 1 mark out, 2 byte in, 3 clear done
  task pulse(input integer k);
    begin
      @(posedge i_clk) o_ev <= 4'h1 << k;
      @(posedge i_clk) o_ev <= 4'h0;
      @(negedge i_clk);
    end
  endtask
endmodule // engine_event_model

// file: verification/tb.sv
// Self-checking bench for the mode-control block
`timescale 1ns/1ps
module tb;
  reg i_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] pstrb = 4'hf;
  reg [27:0] steer_tab = 28'h0443a4a; // Per mode {a_in, b_in, b_out, flush}, mode 0 lowest
  reg [7:0] q;
  reg err;
  integer fail_count = 0, n_tests = 0, m;
  wire [31:0] prdata;
  wire pready, pslverr, halt, ropt, cper, cnow, comp, dec, aout;
  wire [2:0] mode_o;
  wire srst, ain, bin, bout, flush;
  wire [3:0] ev;
  always #12.5 i_clk = ~i_clk;
  engine_event_model i_eng (.i_clk(i_clk), .o_ev(ev));
  codec_mode_control_status i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_record_end_mark(ev[0]), .i_mark_leaves_engine(ev[1]), .i_record_byte_enters(ev[2]),
    .i_dict_clear_done(ev[3]), .o_operation_select_field(mode_o), .o_ratio_optimizer_on(ropt),
    .o_clear_dictionary_per_record(cper), .o_clear_dictionary_now(cnow), .o_halt(halt),
    .o_soft_reset(srst), .o_port_a_in_en(ain), .o_port_a_out_en(aout), .o_port_b_in_en(bin),
    .o_port_b_out_en(bout), .o_compress_en(comp), .o_decompress_en(dec), .o_flush_en(flush));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [8*8:1] nm, input [7:0] s, input [7:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  // Request held until the rising edge that sees pready; data taken at that edge
  task xfer(input w, input [11:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1) @(posedge i_clk);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge i_clk);
    end
  endtask
  task rd(input [11:0] a, input [7:0] e, input [8*8:1] nm);
    begin
      xfer(1'b0, a, 8'h00);
      chk(nm, q, e);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well past the roughly 175 cycles the sequence needs
  initial begin
    #200000;
    fail_count = fail_count + 1;
    summarize;
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(12'h000, 8'he0, "ctl_rst");
    rd(12'h004, 8'h03, "st_rst");
    chk("halt", halt, 8'h01);
    chk("srst", {srst, mode_o}, 8'h0f);
    xfer(1'b1, 12'h000, 8'h5c);
    chk("comp", {comp, ropt, cper}, 8'h07);
    chk("steer_c", {srst, ain, bin, bout, flush}, 8'h0a);
    i_eng.pulse(3);
    rd(12'h000, 8'h58, "clr_now");
    i_eng.pulse(0);
    rd(12'h004, 8'h06, "count");
    i_eng.pulse(1);
    rd(12'h004, 8'h02, "emptied");
    i_eng.pulse(2);
    rd(12'h004, 8'h00, "entered");
    $display("test compression done");
    xfer(1'b1, 12'h000, 8'h4a);
    i_eng.pulse(1);
    chk("eor_halt", halt, 8'h01);
    xfer(1'b1, 12'h000, 8'h4a);
    chk("resume", halt, 8'h00);
    xfer(1'b1, 12'h000, 8'h49);
    chk("pause", halt, 8'h01);
    xfer(1'b1, 12'h000, 8'he0);
    rd(12'h000, 8'he9, "soft_ctl");
    rd(12'h004, 8'h03, "soft_st");
    xfer(1'b1, 12'h000, 8'h81);
    chk("lv_halt", halt, 8'h01);
    xfer(1'b1, 12'h000, 8'h9c);
    chk("dec", {dec, ropt, cper, cnow}, 8'h08);
    xfer(1'b1, 12'h000, 8'h9d);
    xfer(1'b1, 12'h000, 8'ha1);
    xfer(1'b1, 12'h000, 8'ha0);
    chk("quiet", {dec, aout}, 8'h02);
    $display("test pause and decompression done");
    for (m = 0; m < 7; m = m + 1) begin
      xfer(1'b1, 12'h000, 8'he0);
      chk("srst_on", srst, 8'h01);
      xfer(1'b1, 12'h000, {m[2:0], 5'h00});
      chk("steer", {ain, bin, bout, flush}, {4'h0, steer_tab[4*m +: 4]});
      rd(12'h000, {m[2:0], 5'h00}, "mode");
      if (m < 2) rd(12'h004, 8'h02, "pass_st");
    end
    xfer(1'b0, 12'h008, 8'h00);
    chk("slverr", err, 8'h01);
    xfer(1'b1, 12'h000, 8'he0);
    @(posedge i_clk) pstrb <= 4'he;
    xfer(1'b1, 12'h000, 8'h40);
    @(posedge i_clk) pstrb <= 4'hf;
    rd(12'h000, 8'he0, "strb0");
    xfer(1'b1, 12'h004, 8'hff);
    rd(12'h004, 8'h03, "st_ro");
    $display("test modes and refusals done");
    summarize;
  end
endmodule // tb
